// ==== core/dmtc_pkg.sv ====
// dual mode timer with capture: register map, field layouts, reset values
// assumes an APB slave with 32-bit data; each register sits in the low byte of a word
`default_nettype none
package dmtc_pkg;
   // register indices; byte address is four times the index
   localparam logic [29:0] IDX_LOW_MATCH = 30'h00007F18;
   localparam logic [29:0] IDX_HIGH_MATCH = 30'h00007F19;
   localparam logic [29:0] IDX_LOW_COUNT = 30'h00007F1A;
   localparam logic [29:0] IDX_HIGH_COUNT = 30'h00007F1B;
   localparam logic [29:0] IDX_CTRL0 = 30'h00007F1C;
   localparam logic [29:0] IDX_CAP_CTRL = 30'h00007F1D;
   localparam logic [29:0] IDX_CLK_CTRL = 30'h00007F1E;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_PSC = 4'h0;
   localparam logic [2:0] RST_SYNC = 3'h0;
   localparam logic [31:0] RST_WORD = 32'h00000000;

   // count clock select codes
   localparam logic [1:0] CK_SYS = 2'h0;
   localparam logic [1:0] CK_EVENT = 2'h1;
   localparam logic [1:0] CK_FIRST_OSCILLATOR = 2'h2;
   localparam logic [1:0] CK_SECOND_OSCILLATOR = 2'h3;

   // control register 0
   typedef struct packed {
      logic high_run;
      logic high_match_flag;
      logic high_irq_en;
      logic split_mode_select;
      logic capture_read_select;
      logic low_run;
      logic low_match_flag;
      logic low_irq_en;
   } dmtc_ctrl0_s;

   // capture control register; upper three bits read as zero
   typedef struct packed {
      logic [2:0] unused;
      logic [1:0] capture_source_select;
      logic high_capture_flag;
      logic low_capture_flag;
      logic capture_irq_en;
   } dmtc_capctl_s;

   // clock control register
   typedef struct packed {
      logic [1:0] count_clock_select;
      logic event_input_select;
      logic unused;
      logic [3:0] prescale_period;
   } dmtc_clkctl_s;
endpackage
`default_nettype wire

// ==== core/dmtc_timer.sv ====
// dual mode timer with capture: prescaler, two 8-bit counters, match buffers,
// capture registers and an APB register slave
// assumes event inputs are one-cycle pulses on pclk; oscillator pins are asynchronous
//
// Function
// - prescaler runs on low run, split: either
// - prescaler clock chosen by count clock select
// - prescaler matches at prescale period
// - counters clear when stopped or matching
// - low counter runs exactly on low run
// - high run: low run, split: high run
// - low counts prescaler match, split event: pin2
// - high counts low overflow, split: prescaler
// - match on buffer equality, 16 bits joint
// - low buffer tracks stopped, reloads at zero
// - high buffer tracks stopped, reloads at zero
// - low capture source from capture select
// - high capture source, split remaps pins
// - read select returns low capture
// - low counter read only, resets zero
// - split mode select: 16-bit or dual 8-bit
// - low flag sets on match, software clears
// - read select returns high capture
//
// Implementation choice: register access over APB.
`default_nettype none
module dmtc_timer (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // event pulses, synchronous to pclk
   input wire logic event_pin_0,
   input wire logic event_pin_1,
   input wire logic event_pin_2,
   input wire logic event_pin_3,
   input wire logic event_pin_4,
   input wire logic event_pin_5,
   // asynchronous oscillator pins
   input wire logic first_oscillator,
   input wire logic second_oscillator
);

   function automatic logic pick4(input logic [1:0] sel, input logic a, input logic b,
                                  input logic c, input logic d);
      unique case (sel)
         2'h0: pick4 = a;
         2'h1: pick4 = b;
         2'h2: pick4 = c;
         2'h3: pick4 = d;
      endcase
   endfunction

   dmtc_pkg::dmtc_ctrl0_s c0_r, c0_nxt;
   dmtc_pkg::dmtc_capctl_s c1_r, c1_nxt;
   dmtc_pkg::dmtc_clkctl_s c2_r, c2_nxt;
   logic [7:0] lmd_r, lmd_nxt, hmd_r, hmd_nxt;
   logic [7:0] lo_r, lo_nxt, hi_r, hi_nxt;
   logic [7:0] lbuf_r, lbuf_nxt, hbuf_r, hbuf_nxt;
   logic [7:0] lcap_r, lcap_nxt, hcap_r, hcap_nxt;
   logic [3:0] psc_r, psc_nxt;
   logic [2:0] o0_s_r, o0_s_nxt, o1_s_r, o1_s_nxt;
   logic [31:0] prdata_r, prdata_nxt;

   logic split, psc_run, psc_tick, psc_match, hi_run;
   logic lo_inc, hi_inc, lo_hit, hi_hit, lo_match, hi_match, lo_ovf;
   logic lcap_trig, hcap_trig, first_oscillator_rise, second_oscillator_rise;
   logic acc_wr, setup_rd, mapped;
   logic [29:0] idx;

   assign split = c0_r.split_mode_select;
   assign idx = paddr[31:2];
   assign acc_wr = psel & penable & pwrite & mapped;
   assign setup_rd = psel & ~penable & ~pwrite;

   // oscillator rising edges: counted when the second stage is high and the third stage is still low
   assign first_oscillator_rise = o0_s_r[1] & ~o0_s_r[2];
   assign second_oscillator_rise = o1_s_r[1] & ~o1_s_r[2];

   always_comb begin
      mapped = (paddr[1:0] == 2'h0) &&
               (idx == dmtc_pkg::IDX_LOW_MATCH || idx == dmtc_pkg::IDX_HIGH_MATCH ||
                idx == dmtc_pkg::IDX_LOW_COUNT || idx == dmtc_pkg::IDX_HIGH_COUNT ||
                idx == dmtc_pkg::IDX_CTRL0 || idx == dmtc_pkg::IDX_CAP_CTRL ||
                idx == dmtc_pkg::IDX_CLK_CTRL);
   end

   // prescaler enable and count clock
   always_comb begin
      psc_run = split ? (c0_r.low_run | c0_r.high_run) : c0_r.low_run;
      unique case (c2_r.count_clock_select)
         dmtc_pkg::CK_SYS: psc_tick = 1'b1;
         dmtc_pkg::CK_EVENT: begin
            if (split && !c2_r.event_input_select) begin
               psc_tick = 1'b1;
            end else begin
               psc_tick = c2_r.event_input_select ? event_pin_3 : event_pin_2;
            end
         end
         dmtc_pkg::CK_FIRST_OSCILLATOR: psc_tick = first_oscillator_rise;
         dmtc_pkg::CK_SECOND_OSCILLATOR: psc_tick = second_oscillator_rise;
      endcase
      psc_match = psc_run & psc_tick & (psc_r == c2_r.prescale_period);
   end

   // counter steering
   always_comb begin
      hi_run = split ? c0_r.high_run : c0_r.low_run;
      if (split && c2_r.count_clock_select == dmtc_pkg::CK_EVENT) begin
         lo_inc = c0_r.low_run & event_pin_2;
      end else begin
         lo_inc = c0_r.low_run & psc_match;
      end
      if (split) begin
         lo_hit = (lo_r == lbuf_r);
         hi_hit = (hi_r == hbuf_r);
      end else begin
         lo_hit = ({hi_r, lo_r} == {hbuf_r, lbuf_r});
         hi_hit = lo_hit;
      end
      lo_match = lo_inc & lo_hit;
      lo_ovf = lo_inc & ~lo_hit & (lo_r == 8'hFF);
      hi_inc = hi_run & (split ? psc_match : lo_ovf);
      hi_match = split ? (hi_inc & hi_hit) : lo_match;
      lcap_trig = pick4(c1_r.capture_source_select, event_pin_0, event_pin_2,
                        event_pin_4, event_pin_5);
      if (split) begin
         hcap_trig = pick4(c1_r.capture_source_select, event_pin_1, event_pin_3,
                           event_pin_5, event_pin_4);
      end else begin
         hcap_trig = lcap_trig;
      end
   end

   // next state of registers, counters and read data
   always_comb begin
      c0_nxt = c0_r;
      c1_nxt = c1_r;
      c2_nxt = c2_r;
      lmd_nxt = lmd_r;
      hmd_nxt = hmd_r;
      o0_s_nxt = {o0_s_r[1:0], first_oscillator};
      o1_s_nxt = {o1_s_r[1:0], second_oscillator};
      prdata_nxt = prdata_r;

      // software writes; flags can only be cleared by writing zero
      if (acc_wr) begin
         unique case (idx)
            dmtc_pkg::IDX_LOW_MATCH: lmd_nxt = pwdata[7:0];
            dmtc_pkg::IDX_HIGH_MATCH: hmd_nxt = pwdata[7:0];
            dmtc_pkg::IDX_CTRL0: begin
               c0_nxt = dmtc_pkg::dmtc_ctrl0_s'(pwdata[7:0]);
               c0_nxt.low_match_flag = c0_r.low_match_flag & pwdata[1];
               c0_nxt.high_match_flag = c0_r.high_match_flag & pwdata[6];
            end
            dmtc_pkg::IDX_CAP_CTRL: begin
               c1_nxt = dmtc_pkg::dmtc_capctl_s'(pwdata[7:0]);
               c1_nxt.unused = 3'h0;
               c1_nxt.low_capture_flag = c1_r.low_capture_flag & pwdata[1];
               c1_nxt.high_capture_flag = c1_r.high_capture_flag & pwdata[2];
            end
            dmtc_pkg::IDX_CLK_CTRL: begin
               c2_nxt = dmtc_pkg::dmtc_clkctl_s'(pwdata[7:0]);
               c2_nxt.unused = 1'b0;
            end
            default: ;
         endcase
      end

      // hardware sets win over a software clear in the same cycle
      if (lo_match) begin
         c0_nxt.low_match_flag = 1'b1;
      end
      if (split && hi_match) begin
         c0_nxt.high_match_flag = 1'b1;
      end
      if (lcap_trig) begin
         c1_nxt.low_capture_flag = 1'b1;
      end
      if (split && hcap_trig) begin
         c1_nxt.high_capture_flag = 1'b1;
      end

      // prescaler
      if (!psc_run || psc_match) begin
         psc_nxt = dmtc_pkg::RST_PSC;
      end else if (psc_tick) begin
         psc_nxt = 4'(psc_r + 4'h1);
      end else begin
         psc_nxt = psc_r;
      end

      // low counter, not writable by software
      if (!c0_r.low_run || lo_match) begin
         lo_nxt = dmtc_pkg::RST_BYTE;
      end else if (lo_inc) begin
         lo_nxt = 8'(lo_r + 8'h01);
      end else begin
         lo_nxt = lo_r;
      end

      // high counter
      if (!hi_run || hi_match) begin
         hi_nxt = dmtc_pkg::RST_BYTE;
      end else if (hi_inc) begin
         hi_nxt = 8'(hi_r + 8'h01);
      end else begin
         hi_nxt = hi_r;
      end

      // match buffers: follow while stopped, reload at zero while running
      if (!c0_r.low_run || lo_r == 8'h00) begin
         lbuf_nxt = lmd_r;
      end else begin
         lbuf_nxt = lbuf_r;
      end
      if (!hi_run || hi_r == 8'h00) begin
         hbuf_nxt = hmd_r;
      end else begin
         hbuf_nxt = hbuf_r;
      end

      // capture
      lcap_nxt = lcap_trig ? lo_r : lcap_r;
      hcap_nxt = hcap_trig ? hi_r : hcap_r;

      // read data is sampled in the setup cycle and held through the access
      if (setup_rd) begin
         prdata_nxt = dmtc_pkg::RST_WORD;
         if (paddr[1:0] == 2'h0) begin
            unique case (idx)
               dmtc_pkg::IDX_LOW_MATCH: prdata_nxt[7:0] = lmd_r;
               dmtc_pkg::IDX_HIGH_MATCH: prdata_nxt[7:0] = hmd_r;
               dmtc_pkg::IDX_LOW_COUNT:
                  prdata_nxt[7:0] = c0_r.capture_read_select ? lcap_r : lo_r;
               dmtc_pkg::IDX_HIGH_COUNT:
                  prdata_nxt[7:0] = c0_r.capture_read_select ? hcap_r : hi_r;
               dmtc_pkg::IDX_CTRL0: prdata_nxt[7:0] = c0_r;
               dmtc_pkg::IDX_CAP_CTRL: prdata_nxt[7:0] = c1_r;
               dmtc_pkg::IDX_CLK_CTRL: prdata_nxt[7:0] = c2_r;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c0_r <= dmtc_pkg::dmtc_ctrl0_s'(dmtc_pkg::RST_BYTE);
         c1_r <= dmtc_pkg::dmtc_capctl_s'(dmtc_pkg::RST_BYTE);
         c2_r <= dmtc_pkg::dmtc_clkctl_s'(dmtc_pkg::RST_BYTE);
         lmd_r <= dmtc_pkg::RST_BYTE;
         hmd_r <= dmtc_pkg::RST_BYTE;
         lo_r <= dmtc_pkg::RST_BYTE;
         hi_r <= dmtc_pkg::RST_BYTE;
         lbuf_r <= dmtc_pkg::RST_BYTE;
         hbuf_r <= dmtc_pkg::RST_BYTE;
         lcap_r <= dmtc_pkg::RST_BYTE;
         hcap_r <= dmtc_pkg::RST_BYTE;
         psc_r <= dmtc_pkg::RST_PSC;
         o0_s_r <= dmtc_pkg::RST_SYNC;
         o1_s_r <= dmtc_pkg::RST_SYNC;
         prdata_r <= dmtc_pkg::RST_WORD;
      end else begin
         c0_r <= c0_nxt;
         c1_r <= c1_nxt;
         c2_r <= c2_nxt;
         lmd_r <= lmd_nxt;
         hmd_r <= hmd_nxt;
         lo_r <= lo_nxt;
         hi_r <= hi_nxt;
         lbuf_r <= lbuf_nxt;
         hbuf_r <= hbuf_nxt;
         lcap_r <= lcap_nxt;
         hcap_r <= hcap_nxt;
         psc_r <= psc_nxt;
         o0_s_r <= o0_s_nxt;
         o1_s_r <= o1_s_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_read_low_count;
      setup_rd && paddr[1:0] == 2'h0 && idx == dmtc_pkg::IDX_LOW_COUNT;
   endsequence

   sequence s_low_stopped;
      !c0_r.low_run [*2];
   endsequence

   chk_psc_stop:
      assert property (!split && !c0_r.low_run |=> psc_r == 4'h0)
      else $error("prescaler not held at zero while stopped");

   chk_psc_step:
      assert property (psc_run && psc_tick && psc_r != c2_r.prescale_period
                       |=> psc_r == 4'($past(psc_r) + 4'h1))
      else $error("prescaler did not step");

   chk_lo_clear:
      assert property (s_low_stopped |-> lo_r == 8'h00 && (split || psc_r == 4'h0))
      else $error("low counter not cleared while stopped");

   chk_lo_step:
      assert property (c0_r.low_run && psc_match && !lo_hit &&
                       c2_r.count_clock_select != dmtc_pkg::CK_EVENT
                       |=> lo_r == 8'($past(lo_r) + 8'h01))
      else $error("low counter did not advance on prescaler match");

   chk_hi_carry:
      assert property (!split && c0_r.low_run && lo_ovf
                       |=> hi_r == 8'($past(hi_r) + 8'h01) && lo_r == 8'h00)
      else $error("high counter missed low overflow");

   chk_hi_split_stop:
      assert property (split && !c0_r.high_run |=> hi_r == 8'h00)
      else $error("high counter ran without high run in split mode");

   chk_lbuf_track:
      assert property (!c0_r.low_run |=> lbuf_r == $past(lmd_r))
      else $error("low match buffer not tracking while stopped");

   chk_lcap_take:
      assert property (lcap_trig |=> lcap_r == $past(lo_r) && c1_r.low_capture_flag)
      else $error("low capture missed its event");

   chk_flag_set:
      assert property (lo_match |=> c0_r.low_match_flag && lo_r == 8'h00)
      else $error("low match flag not set on match");

   chk_read_sel:
      assert property (s_read_low_count ##0 c0_r.capture_read_select
                       |=> prdata[7:0] == $past(lcap_r) && prdata[31:8] == 24'h000000)
      else $error("read select did not return low capture");

endmodule
`default_nettype wire

// ==== tb/dmtc_tb_top.sv ====
// bench for the dual mode timer: apb traffic, event and oscillator counting, capture
// assumes dmtc_pkg and dmtc_timer are compiled before it
`default_nettype none
module dual_mode_timer_with_capture_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [29:0] A_LM = dmtc_pkg::IDX_LOW_MATCH;
   localparam logic [29:0] A_HM = dmtc_pkg::IDX_HIGH_MATCH;
   localparam logic [29:0] A_LC = dmtc_pkg::IDX_LOW_COUNT;
   localparam logic [29:0] A_HC = dmtc_pkg::IDX_HIGH_COUNT;
   localparam logic [29:0] A_C0 = dmtc_pkg::IDX_CTRL0;
   localparam logic [29:0] A_CC = dmtc_pkg::IDX_CAP_CTRL;
   localparam logic [29:0] A_KC = dmtc_pkg::IDX_CLK_CTRL;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h00000000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [5:0] ev = 6'h00;
   logic [1:0] osc = 2'h0;
   logic [7:0] lfsr_r = 8'h60;
   logic [31:0] rd;
   logic err;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n, p, m, lo, t3, lb, hb;

   dmtc_timer DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .event_pin_0(ev[0]), .event_pin_1(ev[1]), .event_pin_2(ev[2]),
      .event_pin_3(ev[3]), .event_pin_4(ev[4]), .event_pin_5(ev[5]),
      .first_oscillator(osc[0]), .second_oscillator(osc[1])
   );

   always #5 pclk = ~pclk;

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // counter steps produced by a number of prescaler input ticks
   function automatic int ticks(input int evs, input int per);
      return evs / (per + 1);
   endfunction

   // event pin that triggers capture for a source code, low or split high side
   function automatic int cap_pin(input int c, input logic hi);
      if (hi) begin
         return (c == 0) ? 1 : (c == 1) ? 3 : (c == 2) ? 5 : 4;
      end
      return (c == 0) ? 0 : (c == 1) ? 2 : (c == 2) ? 4 : 5;
   endfunction

   task automatic rnd(input int lim, output int v);
      lfsr_r = lfsr_next(lfsr_r);
      v = int'(lfsr_r) % lim;
   endtask

   task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [29:0] a, input logic [7:0] d);
      apb(1'b1, {a, 2'b00}, d);
   endtask

   task automatic rc(input logic [29:0] a, input logic [31:0] e);
      apb(1'b0, {a, 2'b00}, 8'h00);
      check(rd, e);
   endtask

   task automatic pulse(input int pin, input int cnt);
      repeat (cnt) begin
         @(posedge pclk);
         ev[pin] <= 1'b1;
         @(posedge pclk);
         ev[pin] <= 1'b0;
      end
      @(posedge pclk);
   endtask

   // slow oscillator edges, then time for the synchroniser to deliver the last one
   task automatic osc_edges(input int k, input int cnt);
      repeat (cnt) begin
         repeat (4) @(posedge pclk);
         osc[k] <= 1'b1;
         repeat (4) @(posedge pclk);
         osc[k] <= 1'b0;
      end
      repeat (8) @(posedge pclk);
   endtask

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rc(A_LM + 30'(i), 32'h00000000);
      end
      apb(1'b0, {A_KC + 30'h1, 2'b00}, 8'h00);
      check({31'h0, err}, 32'h00000001);
      check(rd, 32'h00000000);
      apb(1'b1, {A_LM, 2'b01}, 8'h5A);
      check({31'h0, err}, 32'h00000001);
      rc(A_LM, 32'h00000000);
      rnd(256, m);
      wr(A_HM, 8'(m));
      rc(A_HM, 32'(m));
      wr(A_LC, 8'hA5);
      rc(A_LC, 32'h00000000);
      // system clock, prescale period 3
      wr(A_LM, 8'hFF);
      wr(A_HM, 8'hFF);
      wr(A_KC, 8'h03);
      wr(A_C0, 8'h14);
      repeat (40) @(posedge pclk);
      rc(A_LC, 32'(ticks(41, 3)));
      wr(A_C0, 8'h00);
      rc(A_LC, 32'h00000000);
      // split mode, prescaler on pin 3, low counter on pin 2
      rnd(4, p);
      wr(A_KC, 8'h60 | 8'(p));
      wr(A_C0, 8'h94);
      rnd(30, n);
      pulse(3, n + 1);
      t3 = n + 1;
      lo = 0;
      rc(A_HC, 32'(ticks(t3, p)));
      rc(A_LC, 32'h00000000);
      for (int c = 0; c < 4; c++) begin
         wr(A_CC, 8'(c << 3));
         pulse(2, 1);
         pulse(3, p + 1);
         lo++;
         t3 += p + 1;
         lb = lo;
         hb = ticks(t3, p);
         pulse(cap_pin(c, 1'b0), 1);
         pulse(cap_pin(c, 1'b1), 1);
         lo += (c == 1);
         t3 += (c == 1);
         pulse(2, 1);
         pulse(3, p + 1);
         lo++;
         t3 += p + 1;
         wr(A_C0, 8'h9C);
         // with source 01 the later pin 2 and pin 3 pulses capture again
         rc(A_LC, 32'(lb + (c == 1)));
         rc(A_HC, 32'((c == 1) ? ticks(t3 - 1, p) : hb));
         wr(A_C0, 8'h94);
      end
      // 16-bit mode across the low byte boundary
      wr(A_C0, 8'h00);
      wr(A_KC, 8'h40);
      wr(A_C0, 8'h80);
      pulse(2, 3);
      rc(A_LC, 32'h00000000);
      rc(A_HC, 32'h00000000);
      rnd(8, m);
      rnd(m + 1, n);
      wr(A_HM, 8'h01);
      wr(A_LM, 8'(m));
      wr(A_CC, 8'h18);
      wr(A_C0, 8'h04);
      pulse(2, 256 + n);
      rc(A_LC, 32'(n));
      rc(A_HC, 32'h00000001);
      pulse(5, 1);
      pulse(2, 1);
      wr(A_C0, 8'h0C);
      rc(A_LC, 32'(n));
      rc(A_HC, 32'h00000001);
      wr(A_C0, 8'h04);
      pulse(2, m - n);
      rc(A_LC, 32'h00000000);
      rc(A_HC, 32'h00000000);
      rc(A_C0, 32'h00000006);
      wr(A_C0, 8'h04);
      rc(A_C0, 32'h00000004);
      // split mode, match data changed while running
      wr(A_C0, 8'h00);
      rnd(8, m);
      m++;
      wr(A_LM, 8'(m));
      wr(A_C0, 8'h14);
      pulse(2, 1);
      wr(A_LM, 8'(m + 3));
      pulse(2, m);
      rc(A_LC, 32'h00000000);
      rc(A_HC, 32'h00000000);
      rc(A_C0, 32'h00000016);
      wr(A_C0, 8'h14);
      pulse(2, m + 3);
      rc(A_LC, 32'(m + 3));
      pulse(2, 1);
      rc(A_LC, 32'h00000000);
      // both oscillator sources
      for (int k = 0; k < 2; k++) begin
         wr(A_C0, 8'h00);
         wr(A_KC, (k == 1) ? 8'hC0 : 8'h80);
         wr(A_C0, 8'h04);
         rnd(6, n);
         osc_edges(k, n + 1);
         rc(A_LC, 32'(n + 1));
      end
      print_verdict();
   end
endmodule
`default_nettype wire
